// ### ctp_pkg.sv
// Package with register map, field layouts and states of the timer pair.
package ctp_pkg;

   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_LOW_MODE  = 8'h04;
   localparam logic [7:0]  ADDR_HIGH_MODE = 8'h08;
   localparam logic [7:0]  ADDR_DUTY      = 8'h0C;
   localparam logic [7:0]  ADDR_LOW_PER   = 8'h10;
   localparam logic [7:0]  ADDR_HIGH_PER  = 8'h14;
   localparam logic [7:0]  ADDR_COUNT     = 8'h18;

   localparam logic [7:0]  RST_MODE       = 8'h00;
   localparam logic [7:0]  RST_COMPARE    = 8'hFF;
   localparam logic [15:0] RST_WIDE       = 16'hFFFF;
   localparam logic [15:0] RST_COUNT      = 16'h0000;

   localparam logic [1:0]  MODE_PPG       = 2'h2;
   localparam logic [1:0]  MODE_TIMER_A   = 2'h0;
   localparam logic [1:0]  MODE_TIMER_B   = 2'h1;

   localparam int          STOP_LAT       = 2;

   typedef struct packed {
      logic [4:0] reserved;
      logic       cascade_bit;
      logic       high_run_bit;
      logic       low_run_bit;
   } ctp_ctrl_type;

   typedef struct packed {
      logic       initial_level_bit;
      logic       buffer_enable;
      logic [2:0] clock_sel;
      logic       ext_input_sel;
      logic [1:0] mode_field;
   } ctp_mode_reg_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PPG  = 3'b010,
      ST_WIDE = 3'b100
   } ctp_state_type;

endpackage : ctp_pkg

// ### ctp_timer.sv
// Cascadable 8/16-bit timer with pulse generator behind an APB slave.
//
// How it works
// - Low unit runs pulse mode when mode is 10, no cascade, no ext input.
// - While low run bit is set the counter advances on each source tick.
// - Duty match drives the pulse output away from its initial level.
// - Period match returns the pulse to initial level and fires low irq.
// - Clearing low run stops, zeroes the counter, restores initial level.
// - Low buffer enable bit turns duty and period buffering off or on.
// - Buffered running writes wait in the buffer until the low irq.
// - Reads of duty and period return the buffered last written value.
// - Writes while stopped load buffer and active compare together, except low period writes with cascade set.
// - Unbuffered running writes act at once; equal value matches at once.
// - Cascade bit joins both counters; only high unit settings apply.
// - Wide timer runs when high mode is 00 or 01 and ext select is 0.
// - Wide compare is high period over low period, committed on high write.
// - Mode register writes are ignored while any run bit is set.
// - Wide match raises high irq, clears the counter and resumes.
// - Clearing high run stops the wide counter and clears it to zero.
// - High buffer enable holds running wide writes until the next match.
// - Unbuffered wide writes act at once; equal value matches at once.
// - Wide writes while stopped load buffer and active value together.
// - Reads of the period bytes always return the last written values.
`timescale 1ns/1ps
`default_nettype none

module ctp_timer
   import ctp_pkg::*;
(
   input  wire logic        pclk,            // APB clock, 10 MHz
   input  wire logic        presetn,         // Asynchronous reset, low
   input  wire logic        psel,            // APB select
   input  wire logic        penable,         // APB enable
   input  wire logic        pwrite,          // APB write direction
   input  wire logic [7:0]  paddr,           // APB byte address
   input  wire logic [31:0] pwdata,          // APB write data
   output var  logic [31:0] prdata,          // APB read data
   output var  logic        pready,          // APB ready
   output var  logic        pslverr,         // APB error, unmapped address
   output var  logic        pulse_out_pin,   // Pulse generator output
   output var  logic        low_timer_irq,   // Low unit period match pulse
   output var  logic        high_timer_irq   // Wide timer match pulse
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations and helper functions.

   ctp_ctrl_type     pair_control_reg;
   ctp_mode_reg_type low_mode_reg;
   ctp_mode_reg_type high_mode_reg;
   ctp_state_type    state;
   ctp_state_type    next_state;
   logic [7:0]       duty_buf;
   logic [7:0]       duty_compare_reg;
   logic [7:0]       low_period_buf;
   logic [7:0]       low_period_reg;
   logic [7:0]       high_period_reg;
   logic [15:0]      wide_buf;
   logic [15:0]      wide_compare_value;
   logic [15:0]      cnt;
   logic [10:0]      presc;
   logic             duty_seen;
   logic             per_seen;
   logic             tick;
   logic             duty_hit;
   logic             period_hit;
   logic             wide_hit;
   logic             cycle_end;
   logic             access;
   logic             wr;
   logic             any_run;
   logic [31:0]      rd_data;
   logic             rd_ok;

   // One source tick per 2^k system clocks, k chosen by the select field.
   function automatic logic sel_tick(input logic [2:0]  sel,
                                     input logic [10:0] p);
      unique case (sel)
         3'h0:    sel_tick = &p[10:0];
         3'h1:    sel_tick = &p[9:0];
         3'h2:    sel_tick = &p[7:0];
         3'h3:    sel_tick = &p[5:0];
         3'h4:    sel_tick = &p[3:0];
         3'h5:    sel_tick = &p[1:0];
         3'h6:    sel_tick = p[0];
         default: sel_tick = 1'b1;
      endcase
   endfunction : sel_tick

   function automatic logic wr_at(input logic       w,
                                  input logic [7:0] a,
                                  input logic [7:0] off);
      wr_at = w && (a == off);
   endfunction : wr_at

   ////////////////////////////////////////////////////////////////////////////
   // Mode selection and match detection.

   always_comb
   begin
      next_state = ST_IDLE;
      if (pair_control_reg.cascade_bit)
      begin
         if (pair_control_reg.high_run_bit && !high_mode_reg.ext_input_sel &&
             (high_mode_reg.mode_field == MODE_TIMER_A ||
              high_mode_reg.mode_field == MODE_TIMER_B))
            next_state = ST_WIDE;
      end
      else if (pair_control_reg.low_run_bit && !low_mode_reg.ext_input_sel &&
               low_mode_reg.mode_field == MODE_PPG)
         next_state = ST_PPG;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         presc <= 11'h000;
      else
         presc <= presc + 11'h001;
   end

   // Matches are checked every cycle, so an equal write hits at once.
   assign tick       = (state == ST_WIDE) ?
                       sel_tick(high_mode_reg.clock_sel, presc) :
                       sel_tick(low_mode_reg.clock_sel, presc);
   assign duty_hit   = (state == ST_PPG) && !duty_seen &&
                       (cnt[7:0] == duty_compare_reg);
   assign period_hit = (state == ST_PPG) && !per_seen &&
                       (cnt[7:0] == low_period_reg);
   assign wide_hit   = (state == ST_WIDE) && !per_seen &&
                       (cnt == wide_compare_value);
   assign cycle_end  = period_hit || wide_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Counter and match flags.

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt <= RST_COUNT;
      else if (state == ST_IDLE)
         cnt <= RST_COUNT;
      else if (cycle_end)
         cnt <= RST_COUNT;
      else if (tick && state == ST_PPG)
         cnt <= {8'h00, cnt[7:0] + 8'h01};
      else if (tick)
         cnt <= cnt + 16'h0001;
   end

   // A flag stops one count value from matching twice.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         per_seen <= 1'b0;
      else if (state == ST_IDLE)
         per_seen <= 1'b0;
      else if (cycle_end)
         per_seen <= (cnt == RST_COUNT);
      else if (tick)
         per_seen <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         duty_seen <= 1'b0;
      else if (state == ST_IDLE || cycle_end || tick)
         duty_seen <= 1'b0;
      else if (duty_hit)
         duty_seen <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pulse output and match events.

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pulse_out_pin <= 1'b0;
      else if (state != ST_PPG)
         pulse_out_pin <= low_mode_reg.initial_level_bit;
      else if (period_hit)
         pulse_out_pin <= low_mode_reg.initial_level_bit;
      else if (duty_hit)
         pulse_out_pin <= !low_mode_reg.initial_level_bit;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         low_timer_irq  <= 1'b0;
         high_timer_irq <= 1'b0;
      end
      else
      begin
         low_timer_irq  <= period_hit;
         high_timer_irq <= wide_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and mode registers.

   assign access  = psel && penable && pready;
   assign wr      = access && pwrite;
   assign any_run = pair_control_reg.low_run_bit ||
                    pair_control_reg.high_run_bit;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pair_control_reg <= ctp_ctrl_type'(RST_MODE);
      else if (wr_at(wr, paddr, ADDR_CTRL))
         pair_control_reg <= ctp_ctrl_type'({5'h00, pwdata[2:0]});
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         low_mode_reg  <= ctp_mode_reg_type'(RST_MODE);
         high_mode_reg <= ctp_mode_reg_type'(RST_MODE);
      end
      else if (!any_run)
      begin
         if (wr_at(wr, paddr, ADDR_LOW_MODE))
            low_mode_reg <= ctp_mode_reg_type'(pwdata[7:0]);
         if (wr_at(wr, paddr, ADDR_HIGH_MODE))
            high_mode_reg <= ctp_mode_reg_type'(pwdata[7:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare registers with their buffers.

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         duty_buf         <= RST_COMPARE;
         duty_compare_reg <= RST_COMPARE;
      end
      else if (wr_at(wr, paddr, ADDR_DUTY))
      begin
         duty_buf <= pwdata[7:0];
         if (state != ST_PPG || !low_mode_reg.buffer_enable)
            duty_compare_reg <= pwdata[7:0];
         else if (period_hit)
            duty_compare_reg <= duty_buf;
      end
      else if (period_hit && low_mode_reg.buffer_enable)
         duty_compare_reg <= duty_buf;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         low_period_buf <= RST_COMPARE;
         low_period_reg <= RST_COMPARE;
      end
      else if (wr_at(wr, paddr, ADDR_LOW_PER))
      begin
         low_period_buf <= pwdata[7:0];
         if (pair_control_reg.cascade_bit)
            low_period_reg <= low_period_reg;
         else if (state != ST_PPG || !low_mode_reg.buffer_enable)
            low_period_reg <= pwdata[7:0];
         else if (period_hit)
            low_period_reg <= low_period_buf;
      end
      else if (period_hit && low_mode_reg.buffer_enable)
         low_period_reg <= low_period_buf;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         high_period_reg    <= RST_COMPARE;
         wide_buf           <= RST_WIDE;
         wide_compare_value <= RST_WIDE;
      end
      else if (wr_at(wr, paddr, ADDR_HIGH_PER))
      begin
         high_period_reg <= pwdata[7:0];
         wide_buf        <= {pwdata[7:0], low_period_buf};
         if (state != ST_WIDE || !high_mode_reg.buffer_enable)
            wide_compare_value <= {pwdata[7:0], low_period_buf};
         else if (wide_hit)
            wide_compare_value <= wide_buf;
      end
      else if (wide_hit && high_mode_reg.buffer_enable)
         wide_compare_value <= wide_buf;
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read path; every transfer takes one wait state.

   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_ok   = 1'b1;
      unique case (paddr)
         ADDR_CTRL:      rd_data = {24'h000000, pair_control_reg};
         ADDR_LOW_MODE:  rd_data = {24'h000000, low_mode_reg};
         ADDR_HIGH_MODE: rd_data = {24'h000000, high_mode_reg};
         ADDR_DUTY:      rd_data = {24'h000000, duty_buf};
         ADDR_LOW_PER:   rd_data = {24'h000000, low_period_buf};
         ADDR_HIGH_PER:  rd_data = {24'h000000, high_period_reg};
         ADDR_COUNT:     rd_data = {16'h0000, cnt};
         default:        rd_ok   = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (psel && penable && !pready)
      begin
         pready  <= 1'b1;
         pslverr <= !rd_ok;
         prdata  <= pwrite ? 32'h0000_0000 : rd_data;
      end
      else
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions and covers.

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_advance;
      state == ST_PPG && next_state == ST_PPG && tick && !cycle_end
      |=> cnt[7:0] == $past(cnt[7:0]) + 8'h01;
   endproperty
   a_advance: assert property (p_advance)
      else $error("low counter did not advance on tick");

   property p_duty_level;
      state == ST_PPG && next_state == ST_PPG && duty_hit && !period_hit
      |=> pulse_out_pin == !low_mode_reg.initial_level_bit;
   endproperty
   a_duty_level: assert property (p_duty_level)
      else $error("duty match did not move the pulse");

   property p_period_irq;
      period_hit && next_state == ST_PPG
      |=> low_timer_irq && cnt == RST_COUNT &&
          pulse_out_pin == low_mode_reg.initial_level_bit;
   endproperty
   a_period_irq: assert property (p_period_irq)
      else $error("period match missed irq, clear or level");

   property p_stop_clear;
      state == ST_PPG && next_state == ST_IDLE
      |-> ##[1:2] (cnt == RST_COUNT &&
          pulse_out_pin == low_mode_reg.initial_level_bit);
   endproperty
   a_stop_clear: assert property (p_stop_clear)
      else $error("stop did not clear counter and pulse");

   property p_buffer_hold;
      wr_at(wr, paddr, ADDR_DUTY) && state == ST_PPG &&
      low_mode_reg.buffer_enable && !period_hit
      |=> duty_compare_reg == $past(duty_compare_reg);
   endproperty
   a_buffer_hold: assert property (p_buffer_hold)
      else $error("buffered duty write reached compare early");

   property p_stopped_load;
      wr_at(wr, paddr, ADDR_DUTY) && state != ST_PPG
      |=> duty_compare_reg == $past(pwdata[7:0]) &&
          duty_buf == $past(pwdata[7:0]);
   endproperty
   a_stopped_load: assert property (p_stopped_load)
      else $error("stopped duty write not loaded");

   property p_read_buf;
      psel && penable && !pready && !pwrite && paddr == ADDR_LOW_PER
      |=> prdata == {24'h000000, $past(low_period_buf)};
   endproperty
   a_read_buf: assert property (p_read_buf)
      else $error("period read did not return the buffer");

   property p_mode_lock;
      wr_at(wr, paddr, ADDR_HIGH_MODE) && any_run
      |=> high_mode_reg == $past(high_mode_reg);
   endproperty
   a_mode_lock: assert property (p_mode_lock)
      else $error("mode write accepted while running");

   property p_wide_commit;
      wr_at(wr, paddr, ADDR_HIGH_PER) && state != ST_WIDE
      |=> wide_compare_value == {$past(pwdata[7:0]), $past(low_period_buf)};
   endproperty
   a_wide_commit: assert property (p_wide_commit)
      else $error("wide compare not committed on high write");

   property p_wide_irq;
      wide_hit && next_state == ST_WIDE
      |=> high_timer_irq && cnt == RST_COUNT;
   endproperty
   a_wide_irq: assert property (p_wide_irq)
      else $error("wide match missed irq or clear");

   c_pulse_cycle: cover property (duty_hit ##[1:600] period_hit);
   c_wide_match:  cover property (wide_hit);
   c_buffer_copy: cover property (period_hit && low_mode_reg.buffer_enable);
   c_read_err:    cover property (pready && pslverr);

endmodule : ctp_timer

`default_nettype wire

// ### ctp_pulse_probe.sv
// Load on the pulse pin that measures high width and counts rising edges.
`timescale 1ns/1ps
`default_nettype none

module ctp_pulse_probe
(
   input  wire logic        pclk,      // Clock shared with the timer
   input  wire logic        presetn,   // Asynchronous reset, low
   input  wire logic        pulse_in,  // Pulse pin of the timer
   output var  logic [15:0] high_len,  // Last completed high width
   output var  logic [15:0] rise_cnt   // Rising edges seen so far
);
   logic        last;
   logic [15:0] run_len;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         last     <= 1'b0;
         run_len  <= 16'h0000;
         high_len <= 16'h0000;
         rise_cnt <= 16'h0000;
      end
      else
      begin
         last <= pulse_in;
         if (pulse_in && !last)
         begin
            rise_cnt <= rise_cnt + 16'h0001;
            run_len  <= 16'h0001;
         end
         else if (pulse_in)
            run_len <= run_len + 16'h0001;
         if (!pulse_in && last)
            high_len <= run_len;
      end
   end
endmodule : ctp_pulse_probe
`default_nettype wire

// ### ctp_timer_tb.sv
// Self-checking testbench for the cascadable timer and pulse generator.
`timescale 1ns/1ps
`default_nettype none

module ctp_timer_tb
   import ctp_pkg::*;
   ;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pulse_out_pin;
   logic        low_timer_irq;
   logic        high_timer_irq;
   logic [15:0] high_len;
   logic [15:0] rise_cnt;
   logic [15:0] r0;
   logic [31:0] rd;
   logic        err;
   logic        lvl;
   int          gap;
   int          n_errors;
   int          cmp_count;

   ctp_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pulse_out_pin(pulse_out_pin), .low_timer_irq(low_timer_irq),
      .high_timer_irq(high_timer_irq));

   ctp_pulse_probe probe_u (.pclk(pclk), .presetn(presetn),
      .pulse_in(pulse_out_pin), .high_len(high_len), .rise_cnt(rise_cnt));

   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One transfer; holds the request until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         chk("pready", 32'h1, 32'h0);
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic chk_rd(input string nm, input logic [7:0] a,
                         input logic [15:0] exp);
      apb(1'b0, a, 8'h00);
      chk(nm, {16'h0000, exp}, rd);
   endtask : chk_rd

   task automatic wait_irq(input logic hi);
      gap = 0;
      do
      begin
         @(posedge pclk);
         gap++;
      end
      while ((hi ? high_timer_irq : low_timer_irq) !== 1'b1 && gap < 2000);
      lvl = pulse_out_pin;
      if (gap >= 2000)
         chk("irq timeout", 32'h1, 32'h0);
   endtask : wait_irq

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #1000000;
      n_errors++;
      give_verdict();
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_errors = 0;
      cmp_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_rd("ctrl", ADDR_CTRL, 16'h0000);
      chk_rd("mode", ADDR_HIGH_MODE, 16'h0000);
      chk_rd("duty", ADDR_DUTY, 16'h00FF);
      chk_rd("hper", ADDR_HIGH_PER, 16'h00FF);
      apb(1'b0, 8'h1C, 8'h00);
      chk("slverr", 32'h1, {31'h0, err});
      $display("test reset done");
      wr(ADDR_LOW_MODE, 8'h3A);
      wr(ADDR_DUTY, 8'h01);
      wr(ADDR_LOW_PER, 8'h05);
      wr(ADDR_CTRL, 8'h01);
      wait_irq(1'b0);
      wait_irq(1'b0);
      chk("low gap", 32'h6, gap);
      chk("high width", 32'h4, {16'h0000, high_len});
      chk("level at irq", 32'h0, {31'h0, lvl});
      wr(ADDR_LOW_MODE, 8'hBA);
      chk_rd("mode lock", ADDR_LOW_MODE, 16'h003A);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_LOW_MODE, 8'hBA);
      wr(ADDR_LOW_PER, 8'h20);
      wr(ADDR_CTRL, 8'h01);
      wait_irq(1'b0);
      chk("init level", 32'h1, {31'h0, lvl});
      repeat (3) @(posedge pclk);
      chk("after duty", 32'h0, {31'h0, pulse_out_pin});
      wr(ADDR_CTRL, 8'h00);
      repeat (2) @(posedge pclk);
      chk("stop level", 32'h1, {31'h0, pulse_out_pin});
      chk_rd("stop count", ADDR_COUNT, 16'h0000);
      $display("test pulse done");
      wr(ADDR_LOW_MODE, 8'h7A);
      wr(ADDR_LOW_PER, 8'h40);
      wr(ADDR_CTRL, 8'h01);
      wait_irq(1'b0);
      wr(ADDR_LOW_PER, 8'h02);
      chk_rd("buffer read", ADDR_LOW_PER, 16'h0002);
      wait_irq(1'b0);
      chk("old period", 32'h1, 32'(gap < 100));
      wait_irq(1'b0);
      chk("new period", 32'h3, gap);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_LOW_MODE, 8'h3A);
      wr(ADDR_LOW_PER, 8'h40);
      wr(ADDR_CTRL, 8'h01);
      wait_irq(1'b0);
      wr(ADDR_LOW_PER, 8'h02);
      wait_irq(1'b0);
      chk("wrap wait", 32'h1, 32'(gap > 200));
      wait_irq(1'b0);
      chk("direct period", 32'h3, gap);
      $display("test buffer done");
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_HIGH_MODE, 8'h38);
      wr(ADDR_LOW_PER, 8'h05);
      wr(ADDR_HIGH_PER, 8'h01);
      r0 = rise_cnt;
      wr(ADDR_CTRL, 8'h06);
      wait_irq(1'b1);
      wait_irq(1'b1);
      chk("wide gap", 32'h106, gap);
      chk("pin idle", {16'h0000, r0}, {16'h0000, rise_cnt});
      wr(ADDR_LOW_PER, 8'h80);
      chk_rd("low byte", ADDR_LOW_PER, 16'h0080);
      chk_rd("high byte", ADDR_HIGH_PER, 16'h0001);
      wait_irq(1'b1);
      wait_irq(1'b1);
      chk("low only", 32'h106, gap);
      wr(ADDR_HIGH_PER, 8'h00);
      wait_irq(1'b1);
      wait_irq(1'b1);
      chk("wide direct", 32'h81, gap);
      wr(ADDR_HIGH_MODE, 8'h78);
      chk_rd("wide lock", ADDR_HIGH_MODE, 16'h0038);
      wr(ADDR_CTRL, 8'h04);
      repeat (2) @(posedge pclk);
      chk_rd("wide stop", ADDR_COUNT, 16'h0000);
      wr(ADDR_HIGH_MODE, 8'h78);
      wr(ADDR_CTRL, 8'h06);
      wait_irq(1'b1);
      wr(ADDR_LOW_PER, 8'h05);
      wr(ADDR_HIGH_PER, 8'h01);
      wait_irq(1'b1);
      chk("wide held", 32'h1, 32'(gap < 129));
      wait_irq(1'b1);
      chk("wide copied", 32'h106, gap);
      $display("test wide done");
      give_verdict();
   end
endmodule : ctp_timer_tb
`default_nettype wire
